// file: hdl/pllt_seq.sv
// pllt_seq: special-instruction sequencer with multiplexed program port
// assumes external latch and memory on the muxed pins, inputs synchronous
`timescale 1ns/1ps
`default_nettype none
module pllt_seq
    import pllt_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_inputs,
    input  wire logic       i_clock_out_pin,
    input  wire logic       i_cko_is_input,
    input  wire logic [3:0] i_accumulator,
    input  wire logic [3:0] i_ram_digit,
    input  wire logic [7:0] i_mem_pins,
    output logic      [7:0] o_mem_pins,
    output logic            o_mem_pins_oe,
    output logic            o_addr_strobe,
    output logic            o_high_addr_bit_low,
    output logic            o_high_addr_bit_high,
    output logic            o_skip_status,
    output logic      [7:0] o_out_latch,
    output logic      [3:0] o_acc_data,
    output logic            o_acc_we,
    output logic      [9:0] o_program_counter
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_two_byte(input logic [7:0] op);
        return op == OP_PREFIX;
    endfunction

    function automatic logic [9:0] table_addr(input logic [9:0] pc_inc,
                                             input logic [3:0] acc,
                                             input logic [3:0] digit);
        return {pc_inc[9:8], acc, digit};
    endfunction

    // ****************************************
    // state
    // ****************************************
    pllt_if lk ();

    pllt_state_t state_q;
    pllt_state_t state_d;
    logic [1:0]  ph_q;
    logic [9:0]  program_counter_q;
    logic [9:0]  program_counter_d;
    logic [9:0]  pc_inc;
    logic [9:0]  save_reg_first_q;
    logic [9:0]  save_reg_second_q;
    logic [9:0]  save_reg_third_q;
    logic        skip_q;
    logic        skip_d;
    logic        do_push;
    logic        do_pop;
    logic        tick;
    logic [7:0]  data;
    logic        acc_we_d;
    logic [3:0]  acc_data_d;
    logic        q_load;
    logic        clr_latches;
    logic        test_ovf;

    assign tick   = ph_q == PH_SAMPLE;
    assign data   = i_mem_pins;
    assign pc_inc = program_counter_q + 10'h001;

    assign lk.tick        = tick;
    assign lk.clr_latches = clr_latches;
    assign lk.test_ovf    = test_ovf;

    pllt_pulse_latch u_latch (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_lines ({i_inputs[3], i_inputs[0]}),
        .lk      (lk)
    );

    pllt_timebase #(
        .WIDTH (TB_WIDTH)
    ) u_timebase (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .tm      (lk)
    );

    // ****************************************
    // instruction cycle phase
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ph_q <= PH_ADDR_ON;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // ****************************************
    // decode and execute
    // ****************************************
    always_comb begin
        state_d           = state_q;
        program_counter_d = program_counter_q;
        skip_d            = skip_q;
        do_push           = 1'b0;
        do_pop            = 1'b0;
        acc_we_d          = 1'b0;
        acc_data_d        = 4'h0;
        q_load            = 1'b0;
        clr_latches       = 1'b0;
        test_ovf          = 1'b0;
        if (tick) begin
            program_counter_d = pc_inc;
            case (state_q)
                ST_FETCH: begin
                    if (skip_q) begin
                        // byte consumed without effect
                        skip_d = 1'b0;
                        if (is_two_byte(data)) begin
                            state_d = ST_SKIP2;
                        end
                    end else if (is_two_byte(data)) begin
                        state_d = ST_PREFIX;
                    end else if (data == OP_LOOKUP) begin
                        do_push           = 1'b1;
                        program_counter_d = table_addr(pc_inc, i_accumulator,
                                                       i_ram_digit);
                        state_d           = ST_LOOKUP;
                    end else if (data == OP_IND_JUMP) begin
                        program_counter_d = table_addr(pc_inc, i_accumulator,
                                                       i_ram_digit);
                        state_d           = ST_IJUMP;
                    end else if (data == OP_TB_SKIP) begin
                        test_ovf = 1'b1;
                        skip_d   = lk.ovf;
                    end else if (data[7:6] == OP_PAGE_JUMP) begin
                        program_counter_d = {pc_inc[9:6], data[5:0]};
                    end else if (data[7:6] == OP_PAGE_CALL) begin
                        do_push           = 1'b1;
                        program_counter_d = {SUB_PAGE, data[5:0]};
                    end
                end
                ST_PREFIX: begin
                    state_d = ST_FETCH;
                    if (data == OP2_READ_DIR) begin
                        acc_we_d   = 1'b1;
                        acc_data_d = i_inputs;
                    end else if (data == OP2_READ_LAT) begin
                        acc_we_d      = 1'b1;
                        acc_data_d[3] = lk.latch_vals[1];
                        acc_data_d[2] = i_cko_is_input ? i_clock_out_pin : 1'b1;
                        acc_data_d[1] = 1'b0;
                        acc_data_d[0] = lk.latch_vals[0];
                        clr_latches   = 1'b1;
                    end
                end
                ST_SKIP2: begin
                    state_d = ST_FETCH;
                end
                ST_LOOKUP: begin
                    q_load            = 1'b1;
                    do_pop            = 1'b1;
                    program_counter_d = save_reg_first_q;
                    state_d           = ST_FETCH;
                end
                ST_IJUMP: begin
                    program_counter_d = {program_counter_q[9:8], data};
                    state_d           = ST_FETCH;
                end
                default: begin
                    state_d = ST_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_FETCH;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            program_counter_q <= PC_RESET;
        end else begin
            program_counter_q <= program_counter_d;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    // ****************************************
    // three-level save stack
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            save_reg_first_q  <= PC_RESET;
            save_reg_second_q <= PC_RESET;
            save_reg_third_q  <= PC_RESET;
        end else if (do_push) begin
            save_reg_first_q  <= pc_inc;
            save_reg_second_q <= save_reg_first_q;
            save_reg_third_q  <= save_reg_second_q;
        end else if (do_pop) begin
            save_reg_first_q  <= save_reg_second_q;
            save_reg_second_q <= save_reg_third_q;
        end
    end

    // ****************************************
    // output latch and accumulator write
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_out_latch <= Q_RESET;
        end else if (q_load) begin
            o_out_latch <= data;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_acc_we   <= 1'b0;
            o_acc_data <= 4'h0;
        end else begin
            o_acc_we <= acc_we_d;
            if (acc_we_d) begin
                o_acc_data <= acc_data_d;
            end
        end
    end

    // ****************************************
    // multiplexed program memory port
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_addr_strobe <= 1'b0;
            o_mem_pins_oe <= 1'b0;
            o_mem_pins    <= 8'h00;
        end else if (ph_q == PH_ADDR_ON) begin
            o_addr_strobe <= 1'b1;
            o_mem_pins_oe <= 1'b1;
            o_mem_pins    <= program_counter_q[7:0];
        end else if (ph_q == PH_ADDR_OFF) begin
            o_addr_strobe <= 1'b0;
            o_mem_pins_oe <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_high_addr_bit_low  <= 1'b0;
            o_high_addr_bit_high <= 1'b0;
        end else if (ph_q == PH_ADDR_ON) begin
            o_high_addr_bit_low  <= program_counter_q[8];
            o_high_addr_bit_high <= program_counter_q[9];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_skip_status     <= 1'b0;
            o_program_counter <= PC_RESET;
        end else begin
            o_skip_status     <= skip_d;
            o_program_counter <= program_counter_d;
        end
    end

endmodule
`default_nettype wire

// file: hdl/pllt_pkg.sv
// pllt_pkg: shared constants for the special-instruction sequencer
// assumes one 25 MHz clock and an instruction cycle of four clocks
package pllt_pkg;

    // ****************************************
    // instruction cycle phases
    // ****************************************
    localparam int         PH_W          = 2;
    localparam logic [1:0] PH_ADDR_ON    = 2'h0;
    localparam logic [1:0] PH_ADDR_OFF   = 2'h2;
    localparam logic [1:0] PH_SAMPLE     = 2'h3;

    // ****************************************
    // counts and reset values
    // ****************************************
    localparam int         TB_WIDTH      = 10;
    localparam logic [9:0] TB_RESET      = 10'h000;
    localparam logic [9:0] TB_LAST       = 10'h3ff;
    localparam int         LOW_TIMES     = 2;
    localparam logic [1:0] LOW_CNT_RESET = 2'h0;
    localparam logic [9:0] PC_RESET      = 10'h000;
    localparam logic [7:0] Q_RESET       = 8'h00;
    localparam logic [3:0] SUB_PAGE      = 4'h2;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_PREFIX     = 8'h33;
    localparam logic [7:0] OP2_READ_DIR  = 8'h28;
    localparam logic [7:0] OP2_READ_LAT  = 8'h29;
    localparam logic [7:0] OP_LOOKUP     = 8'h1f;
    localparam logic [7:0] OP_IND_JUMP   = 8'h0f;
    localparam logic [7:0] OP_TB_SKIP    = 8'h41;
    localparam logic [1:0] OP_PAGE_JUMP  = 2'h3;
    localparam logic [1:0] OP_PAGE_CALL  = 2'h2;

    typedef enum logic [2:0] {
        ST_FETCH  = 3'b000,
        ST_PREFIX = 3'b001,
        ST_SKIP2  = 3'b010,
        ST_LOOKUP = 3'b011,
        ST_IJUMP  = 3'b100
    } pllt_state_t;

endpackage

// file: hdl/pllt_if.sv
// pllt_if: links the sequencer with its pulse latches and time base
// assumes all members sit in the i_clock domain
`timescale 1ns/1ps
`default_nettype none
interface pllt_if;
    logic       tick;
    logic       clr_latches;
    logic       test_ovf;
    logic [1:0] latch_vals;
    logic       ovf;

    modport seq   (output tick, output clr_latches, output test_ovf,
                   input latch_vals, input ovf);
    modport latch (input tick, input clr_latches, output latch_vals);
    modport timer (input tick, input test_ovf, output ovf);
endinterface
`default_nettype wire

// file: hdl/pllt_pulse_latch.sv
// pllt_pulse_latch: two falling-edge pulse latches with low-time filter
// assumes i_lines synchronous to i_clock; tick marks each instruction cycle
`timescale 1ns/1ps
`default_nettype none
module pllt_pulse_latch
    import pllt_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_lines,
    pllt_if.latch           lk
);
    logic [1:0] prev_q;
    logic [1:0] armed_q;
    logic [1:0] low_cnt_q [2];
    logic [1:0] latch_q;

    // ****************************************
    // low-going pulse qualification
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev_q     <= 2'h3;
            armed_q    <= 2'h0;
            latch_q    <= 2'h0;
            low_cnt_q[0] <= LOW_CNT_RESET;
            low_cnt_q[1] <= LOW_CNT_RESET;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (lk.tick) begin
                    prev_q[k] <= i_lines[k];
                    if (prev_q[k] && !i_lines[k]) begin
                        armed_q[k]   <= 1'b1;
                        low_cnt_q[k] <= 2'h1;
                    end else if (!i_lines[k] && armed_q[k]) begin
                        low_cnt_q[k] <= low_cnt_q[k] + 2'h1;
                    end else begin
                        armed_q[k] <= 1'b0;
                    end
                end
                // set wins over the clear of a read
                if (armed_q[k] && !i_lines[k] && 32'(low_cnt_q[k]) >= LOW_TIMES) begin
                    latch_q[k] <= 1'b1;
                    armed_q[k] <= 1'b0;
                end else if (lk.clr_latches) begin
                    latch_q[k] <= 1'b0;
                end
            end
        end
    end

    assign lk.latch_vals = latch_q;
endmodule
`default_nettype wire

// file: hdl/pllt_timebase.sv
// pllt_timebase: free-running 10-bit time base with overflow latch
// assumes tick is one clock per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module pllt_timebase
    import pllt_pkg::*;
#(
    parameter int WIDTH = TB_WIDTH
)(
    input  wire logic i_clock,
    input  wire logic i_rst,
    pllt_if.timer     tm
);
    logic [WIDTH-1:0] count_q;
    logic             ovf_q;

    // ****************************************
    // divide by 1024, never cleared by a test
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_q <= WIDTH'(TB_RESET);
        end else if (tm.tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ovf_q <= 1'b0;
        end else if (tm.tick && (count_q == WIDTH'(TB_LAST))) begin
            ovf_q <= 1'b1;
        end else if (tm.test_ovf) begin
            ovf_q <= 1'b0;
        end
    end

    assign tm.ovf = ovf_q;
endmodule
`default_nettype wire

// file: testbench/pllt_mem_model.sv
// pllt_mem_model: address latch and program memory on the muxed pins
// assumes strobe high marks the address phase, low the data phase
`timescale 1ns/1ps
`default_nettype none
module pllt_mem_model (
    input  wire logic       i_strobe,
    input  wire logic       i_addr_b9,
    input  wire logic       i_addr_b8,
    input  wire logic [7:0] i_bus,
    output var  logic [7:0] o_data
);
    // ********
    // memory
    // ********
    logic [7:0] rom [0:1023];
    logic [7:0] addr_low;
    initial o_data = 8'h00;
    always @(i_strobe or i_bus) if (i_strobe) addr_low = i_bus;
    always @(posedge i_strobe) o_data = ~o_data;
    always @(negedge i_strobe) #8 o_data = rom[{i_addr_b9, i_addr_b8, addr_low}];
endmodule
`default_nettype wire

// file: testbench/pllt_seq_checker.sv
// pllt_seq_checker: timing checks on the sequencer's ports
// assumes bound into pllt_seq, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pllt_seq_checker
    import pllt_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic [3:0] i_inputs,
    input wire logic       i_clock_out_pin,
    input wire logic       i_cko_is_input,
    input wire logic [7:0] i_mem_pins,
    input wire logic [7:0] o_mem_pins,
    input wire logic       o_mem_pins_oe,
    input wire logic       o_addr_strobe,
    input wire logic       o_high_addr_bit_low,
    input wire logic       o_high_addr_bit_high,
    input wire logic       o_skip_status,
    input wire logic [7:0] o_out_latch,
    input wire logic [3:0] o_acc_data,
    input wire logic       o_acc_we,
    input wire logic [9:0] o_program_counter
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_take(logic [7:0] op);
        $fell(o_addr_strobe) && (i_mem_pins == op) && !o_skip_status;
    endsequence
    sequence s_pair(logic [7:0] op);
        s_take(OP_PREFIX) ##4 ($fell(o_addr_strobe) && (i_mem_pins == op));
    endsequence
    a_strobe_shape: assert property (
        $rose(o_addr_strobe) |-> ##1 o_addr_strobe ##1 !o_addr_strobe [*2] ##1 o_addr_strobe)
        else $error("strobe cycle shape wrong");
    a_oe_tracks: assert property (o_mem_pins_oe == o_addr_strobe)
        else $error("pin enable differs from strobe");
    a_addr_out: assert property (
        $rose(o_addr_strobe) |->
        {o_high_addr_bit_high, o_high_addr_bit_low, o_mem_pins} == o_program_counter)
        else $error("address pins differ from program counter");
    a_addr_hold: assert property (
        !$rose(o_addr_strobe) |->
        $stable({o_high_addr_bit_high, o_high_addr_bit_low, o_mem_pins}))
        else $error("address pins moved within a cycle");
    a_direct_read: assert property (
        s_pair(OP2_READ_DIR) |=> o_acc_we && (o_acc_data == $past(i_inputs)))
        else $error("direct read value wrong");
    a_latch_bit1: assert property (
        s_pair(OP2_READ_LAT) |=> o_acc_we && !o_acc_data[1])
        else $error("latch read bit 1 not zero");
    a_latch_bit2: assert property (
        s_pair(OP2_READ_LAT) |=>
        o_acc_data[2] == ($past(i_cko_is_input) ? $past(i_clock_out_pin) : 1'b1))
        else $error("latch read bit 2 wrong");
    a_lookup_load: assert property (
        s_take(OP_LOOKUP) ##4 $fell(o_addr_strobe) |=> o_out_latch == $past(i_mem_pins))
        else $error("table byte not in output latch");
    a_skip_hold: assert property (
        $rose(o_skip_status) |-> o_skip_status [*4] ##[1:5] !o_skip_status)
        else $error("skip status length wrong");
endmodule
bind pllt_seq pllt_seq_checker u_checker (.i_clock(i_clock), .i_rst(i_rst),
    .i_inputs(i_inputs), .i_clock_out_pin(i_clock_out_pin), .i_cko_is_input(i_cko_is_input),
    .i_mem_pins(i_mem_pins), .o_mem_pins(o_mem_pins), .o_mem_pins_oe(o_mem_pins_oe),
    .o_addr_strobe(o_addr_strobe), .o_high_addr_bit_low(o_high_addr_bit_low),
    .o_high_addr_bit_high(o_high_addr_bit_high), .o_skip_status(o_skip_status),
    .o_out_latch(o_out_latch), .o_acc_data(o_acc_data), .o_acc_we(o_acc_we),
    .o_program_counter(o_program_counter));
`default_nettype wire

// file: testbench/pllt_seq_test.sv
// pllt_seq_test: self-checking bench for the sequencer
// assumes the memory model on the muxed pins, one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module pllt_seq_test;
    import pllt_pkg::*;
    // ********
    // signals
    // ********
    logic       i_clock, i_rst, i_clock_out_pin, i_cko_is_input;
    logic [3:0] i_inputs, i_accumulator, i_ram_digit, o_acc_data;
    logic [7:0] o_mem_pins, m_data, o_out_latch;
    wire  logic [7:0] pins_bus;
    logic       o_mem_pins_oe, o_addr_strobe, o_high_addr_bit_low, o_high_addr_bit_high;
    logic       o_skip_status, o_acc_we, strobe_prev, skip_prev;
    logic [9:0] o_program_counter;
    logic [9:0] addr_q [$];
    logic [3:0] acc_q [$];
    int         err_count, samples_checked, skip_rises, skip_at;

    assign pins_bus = o_mem_pins_oe ? o_mem_pins : m_data;

    pllt_seq uut (.i_clock(i_clock), .i_rst(i_rst), .i_inputs(i_inputs),
        .i_clock_out_pin(i_clock_out_pin), .i_cko_is_input(i_cko_is_input),
        .i_accumulator(i_accumulator), .i_ram_digit(i_ram_digit), .i_mem_pins(pins_bus),
        .o_mem_pins(o_mem_pins), .o_mem_pins_oe(o_mem_pins_oe), .o_addr_strobe(o_addr_strobe),
        .o_high_addr_bit_low(o_high_addr_bit_low), .o_high_addr_bit_high(o_high_addr_bit_high),
        .o_skip_status(o_skip_status), .o_out_latch(o_out_latch), .o_acc_data(o_acc_data),
        .o_acc_we(o_acc_we), .o_program_counter(o_program_counter));
    pllt_mem_model mem (.i_strobe(o_addr_strobe), .i_addr_b9(o_high_addr_bit_high),
        .i_addr_b8(o_high_addr_bit_low), .i_bus(pins_bus), .o_data(m_data));

    always #20 i_clock = ~i_clock;

    always @(posedge i_clock) begin
        if (o_addr_strobe === 1'b1 && strobe_prev === 1'b0) begin
            addr_q.push_back({o_high_addr_bit_high, o_high_addr_bit_low, o_mem_pins});
        end
        if (o_acc_we === 1'b1) begin
            acc_q.push_back(o_acc_data);
        end
        if (o_skip_status === 1'b1 && skip_prev === 1'b0) begin
            skip_rises++;
            skip_at = addr_q.size();
        end
        strobe_prev <= o_addr_strobe;
        skip_prev <= o_skip_status;
    end

    // ********
    // tasks
    // ********
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_for(input int n, input bit use_acc);
        int k;
        k = 0;
        while ((use_acc ? acc_q.size() : addr_q.size()) < n && k < 16 * n + 64) begin
            @(posedge i_clock);
            #2;
            k++;
        end
        if ((use_acc ? acc_q.size() : addr_q.size()) < n) begin
            err_count++;
            $display("FAIL wait expected %0d events seen fewer", n);
            print_verdict();
        end
    endtask

    task automatic do_reset(input logic [7:0] fill);
        for (int a = 0; a < 1024; a++) begin
            mem.rom[a] = fill;
        end
        i_rst = 1'b1;
        repeat (10) @(posedge i_clock);
        #2;
        addr_q.delete();
        acc_q.delete();
        skip_rises = 0;
        i_rst = 1'b0;
    endtask

    task automatic test_flow();
        logic [9:0] exp_addr [10];
        exp_addr = '{10'h000, 10'h0be, 10'h0bf, 10'h0fe, 10'h0ff,
                     10'h159, 10'h100, 10'h159, 10'h13c, 10'h13d};
        i_accumulator = 4'h5;
        i_ram_digit = 4'h9;
        do_reset(8'h00);
        mem.rom[10'h000] = 8'hbe;
        mem.rom[10'h0bf] = 8'hfe;
        mem.rom[10'h0ff] = OP_LOOKUP;
        mem.rom[10'h100] = OP_IND_JUMP;
        mem.rom[10'h159] = 8'h3c;
        wait_for(10, 1'b0);
        for (int k = 0; k < 10; k++) begin
            check("fetch address", addr_q[k], exp_addr[k]);
        end
        check("out latch", {2'b00, o_out_latch}, 10'h03c);
    endtask

    task automatic test_latches();
        i_inputs = 4'hf;
        i_cko_is_input = 1'b1;
        i_clock_out_pin = 1'b0;
        do_reset(8'h00);
        mem.rom[10'h008] = OP_PREFIX;
        mem.rom[10'h009] = OP2_READ_LAT;
        mem.rom[10'h00a] = OP_PREFIX;
        mem.rom[10'h00b] = OP2_READ_LAT;
        mem.rom[10'h00c] = OP_PREFIX;
        mem.rom[10'h00d] = OP2_READ_DIR;
        mem.rom[10'h00e] = OP_PREFIX;
        mem.rom[10'h00f] = OP2_READ_LAT;
        wait_for(2, 1'b0);
        i_inputs = 4'h6;
        repeat (4) @(posedge i_clock);
        #2;
        i_inputs = 4'h7;
        repeat (8) @(posedge i_clock);
        #2;
        i_inputs = 4'hf;
        wait_for(1, 1'b1);
        i_inputs = 4'hb;
        i_cko_is_input = 1'b0;
        wait_for(3, 1'b1);
        check("latch read", {6'h00, acc_q[0]}, 10'h008);
        check("latch reread", {6'h00, acc_q[1]}, 10'h004);
        check("direct read", {6'h00, acc_q[2]}, 10'h00b);
        i_cko_is_input = 1'b1;
        i_clock_out_pin = 1'b1;
        wait_for(4, 1'b1);
        check("latch pin level", {6'h00, acc_q[3]}, 10'h004);
    endtask

    task automatic test_timer();
        int rises;
        do_reset(OP_TB_SKIP);
        // skipped two-byte pair right after each test at address 0 but the first
        mem.rom[10'h001] = OP_PREFIX;
        mem.rom[10'h002] = 8'hc5;
        wait_for(512, 1'b0);
        rises = skip_rises;
        wait_for(2560, 1'b0);
        check("overflow count", 10'(skip_rises - rises), 10'h002);
        check("pc advance", addr_q[2500] - addr_q[1500], 10'h3e8);
        // second rise after the fetch of cycle 2048: counter kept running
        check("overflow phase", 10'(skip_at - 2048), 10'h001);
    endtask

    initial begin
        i_clock = 1'b0;
        i_rst = 1'b1;
        i_inputs = 4'hf;
        i_accumulator = 4'h0;
        i_ram_digit = 4'h0;
        i_clock_out_pin = 1'b0;
        i_cko_is_input = 1'b0;
        strobe_prev = 1'b0;
        skip_prev = 1'b0;
        err_count = 0;
        samples_checked = 0;
        skip_rises = 0;
        skip_at = 0;
        test_flow();
        test_latches();
        test_timer();
        print_verdict();
    end
endmodule
`default_nettype wire
